/* dv/scs_sysconfig_regs_checker.sv */
// checker: assertions on the system configuration register ports
`timescale 1ns/1ps
module scs_sysconfig_regs_checker
  import scs_pkg::*;
(
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rst,
  // brown-out
  input wire logic                 bod_irq_detect,
  input wire logic                 bod_rst_detect,
  input wire logic [1:0]           brownout_reset_level,
  input wire logic [1:0]           brownout_irq_level,
  input wire logic                 brownout_reset_enable,
  input wire logic                 bod_irq_req,
  input wire logic                 bod_chip_reset,
  input wire logic                 bod_wake_req,
  // tick and latency
  input wire logic [SCS_CAL_W-1:0] tick_timer_calibration_readback,
  input wire logic                 irq_pending,
  input wire logic                 irq_service,
  input wire logic [SCS_LAT_W-1:0] irq_latency
);
  logic [7:0] wait_r;

  // cycles the request has waited
  always_ff @(posedge mclk) begin
    if (rst || !irq_pending) wait_r <= 8'h00;
    else if (wait_r != 8'hff) wait_r <= wait_r + 8'h01;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_irq_fol; !$past(rst) |-> bod_irq_req == $past(bod_irq_detect); endproperty
  a_irq_fol: assert property (p_irq_fol) else $error("irq request off");
  property p_chip_rst;
    !$past(rst) |-> bod_chip_reset == $past(bod_rst_detect && brownout_reset_enable);
  endproperty
  a_chip_rst: assert property (p_chip_rst) else $error("chip reset off");
  property p_wake;
    !$past(rst) |->
      bod_wake_req == $past(bod_irq_detect || (bod_rst_detect && brownout_reset_enable));
  endproperty
  a_wake: assert property (p_wake) else $error("wake off");
  property p_lat_min; irq_service |-> irq_pending && wait_r >= irq_latency; endproperty
  a_lat_min: assert property (p_lat_min) else $error("service too early");
  property p_lat_rel; irq_pending && wait_r >= irq_latency |-> irq_service; endproperty
  a_lat_rel: assert property (p_lat_rel) else $error("service late");
  property p_lat_rst; $fell(rst) |-> irq_latency == 8'h10; endproperty
  a_lat_rst: assert property (p_lat_rst) else $error("latency reset");
  property p_cal_rst; $fell(rst) |-> tick_timer_calibration_readback == 26'h000_0000; endproperty
  a_cal_rst: assert property (p_cal_rst) else $error("cal reset");
  property p_bod_rst;
    $fell(rst) |-> {brownout_reset_enable, brownout_irq_level, brownout_reset_level} == 5'h00;
  endproperty
  a_bod_rst: assert property (p_bod_rst) else $error("bod reset");
endmodule : scs_sysconfig_regs_checker

bind scs_sysconfig_regs scs_sysconfig_regs_checker u_chk (
  .mclk(mclk), .rst(rst), .bod_irq_detect(bod_irq_detect), .bod_rst_detect(bod_rst_detect),
  .brownout_reset_level(brownout_reset_level), .brownout_irq_level(brownout_irq_level),
  .brownout_reset_enable(brownout_reset_enable), .bod_irq_req(bod_irq_req),
  .bod_chip_reset(bod_chip_reset), .bod_wake_req(bod_wake_req),
  .tick_timer_calibration_readback(tick_timer_calibration_readback),
  .irq_pending(irq_pending), .irq_service(irq_service), .irq_latency(irq_latency));

/* dv/scs_sysconfig_regs_tb.sv */
// testbench: register bus tests for the system configuration registers
`timescale 1ns/1ps
module scs_sysconfig_regs_tb
  import scs_pkg::*;
;
  localparam logic [23:0] P0 = 24'h5a_c3e1;
  localparam logic [31:0] P1 = 32'h9e37_79b9;
  logic          mclk, rst, bird, brd, ren, irq_req, chip_rst, wake, pend, svc;
  scs_axil_req_s req;
  scs_axil_rsp_s rsp;
  logic [23:0]   p0;
  logic [31:0]   p1, d;
  logic [1:0]    rlev, ilev, r;
  logic [25:0]   cal;
  logic [7:0]    lat;
  logic [7:0]    lv [4] = '{8'h00, 8'h01, 8'h07, 8'hff};
  int            mismatches, compares, n;

  scs_sysconfig_regs DUT (
    .mclk(mclk), .rst(rst), .axil_req(req), .axil_rsp(rsp), .port0_pins(p0), .port1_pins(p1),
    .bod_irq_detect(bird), .bod_rst_detect(brd), .brownout_reset_level(rlev),
    .brownout_irq_level(ilev), .brownout_reset_enable(ren), .bod_irq_req(irq_req),
    .bod_chip_reset(chip_rst), .bod_wake_req(wake), .tick_timer_calibration_readback(cal),
    .irq_pending(pend), .irq_service(svc), .irq_latency(lat));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
    bit done;
    @(posedge mclk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= s;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    done = 0;
    while (!done) begin
      @(posedge mclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        r = rsp.bresp;
        req.bready <= 1'b0;
        done = 1;
      end
    end
  endtask : wr

  task automatic rd(input logic [31:0] a);
    bit done;
    @(posedge mclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    done = 0;
    while (!done) begin
      @(posedge mclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        done = 1;
      end
    end
  endtask : rd

  task automatic ev(input logic i, input logic b);
    @(posedge mclk);
    bird <= i;
    brd <= b;
    @(posedge mclk);
    @(negedge mclk);
  endtask : ev

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    req = '0;
    rst = 1'b1;
    p0 = P0;
    p1 = P1;
    bird = 1'b0;
    brd = 1'b0;
    pend = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    p0 <= ~P0;
    p1 <= ~P1;
    rd(SCS_PORT0_CAP_ADDR); chk("cap0", d, {8'h00, P0});
    rd(SCS_PORT1_CAP_ADDR); chk("cap1", d, P1);
    rd(SCS_BOD_CTRL_ADDR); chk("bod", d, 32'h0000_0000);
    rd(SCS_TICK_CAL_ADDR); chk("cal", d, 32'h0000_0000);
    rd(SCS_IRQ_LAT_ADDR); chk("lat", d, 32'h0000_0010);
    $display("test reset done");
    wr(SCS_PORT0_CAP_ADDR, 32'hffff_ffff, 4'hf); chk("cap0 resp", r, SCS_RESP_OKAY);
    wr(SCS_PORT1_CAP_ADDR, 32'h0000_0000, 4'hf); chk("cap1 resp", r, SCS_RESP_OKAY);
    rd(SCS_PORT0_CAP_ADDR); chk("cap0 ro", d, {8'h00, P0});
    rd(SCS_PORT1_CAP_ADDR); chk("cap1 ro", d, P1);
    $display("test capture done");
    for (int i = 0; i < 32; i++) begin
      if (i[3:2] == 2'h0) continue;
      wr(SCS_BOD_CTRL_ADDR, 32'hffff_ffe0 | i, 4'hf);
      rd(SCS_BOD_CTRL_ADDR); chk("bod rb", d, i);
      chk("rst lev", rlev, i[1:0]);
      chk("irq lev", ilev, i[3:2]);
      chk("rst en", ren, i[4]);
    end
    ev(1'b1, 1'b1);
    chk("chip rst", chip_rst, 1'b1);
    chk("irq req", irq_req, 1'b1);
    wr(SCS_BOD_CTRL_ADDR, 32'h0000_0004, 4'hf);
    ev(1'b0, 1'b1);
    chk("chip rst off", chip_rst, 1'b0);
    chk("wake off", wake, 1'b0);
    chk("irq req off", irq_req, 1'b0);
    ev(1'b1, 1'b0);
    chk("wake irq", wake, 1'b1);
    ev(1'b0, 1'b0);
    $display("test brownout done");
    wr(SCS_TICK_CAL_ADDR, 32'hffff_ffff, 4'hf);
    wr(SCS_TICK_CAL_ADDR, 32'h0000_0000, 4'h1);
    rd(SCS_TICK_CAL_ADDR); chk("cal rb", d, 32'h03ff_ff00);
    chk("cal out", cal, 26'h3ff_ff00);
    $display("test calibration done");
    for (int k = 0; k < 4; k++) begin
      wr(SCS_IRQ_LAT_ADDR, 32'hffff_ff00 | lv[k], 4'hf);
      rd(SCS_IRQ_LAT_ADDR); chk("lat rb", d, lv[k]);
      chk("lat out", lat, lv[k]);
      @(posedge mclk);
      pend <= 1'b1;
      n = 0;
      @(negedge mclk);
      while (svc !== 1'b1) begin
        @(negedge mclk);
        n++;
      end
      chk("lat cycles", n, lv[k]);
      @(posedge mclk);
      pend <= 1'b0;
    end
    $display("test latency done");
    wr(32'h4004_8108, 32'hffff_ffff, 4'hf); chk("bad wresp", r, SCS_RESP_SLVERR);
    rd(32'h4004_8108); chk("bad rresp", r, SCS_RESP_SLVERR);
    chk("bad data", d, 32'h0000_0000);
    $display("test unmapped done");
    summarize();
  end
endmodule : scs_sysconfig_regs_tb

/* logic/scs_irq_latency.sv */
// module: holds back an interrupt request for a minimum number of cycles
`timescale 1ns/1ps
module scs_irq_latency
  import scs_pkg::*;
#(
  parameter int unsigned LAT_W = SCS_LAT_W
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // control
  input  wire logic [LAT_W-1:0] latency,
  // request and release
  input  wire logic             irq_pending,
  output logic                  irq_service
);

  typedef struct packed {
    logic [LAT_W-1:0] waited;
  } scs_lat_state_s;

  scs_lat_state_s st_r;
  scs_lat_state_s st_nxt;

  // count cycles spent pending, saturating
  always_comb begin
    st_nxt = st_r;
    if (rst || !irq_pending) begin
      st_nxt.waited = '0;
    end else if (st_r.waited != '1) begin
      st_nxt.waited = st_r.waited + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  // never earlier than the programmed count
  assign irq_service = irq_pending && (st_r.waited >= latency); // see RULE_11

endmodule : scs_irq_latency

/* logic/scs_por_capture.sv */
// module: holds pin levels seen while power-on reset is applied
`timescale 1ns/1ps
module scs_por_capture
  import scs_pkg::*;
#(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // pins
  input  wire logic [WIDTH-1:0] pins,
  // captured levels
  output logic      [WIDTH-1:0] captured
);

  typedef struct packed {
    logic [WIDTH-1:0] lev;
  } scs_cap_state_s;

  scs_cap_state_s st_r;
  scs_cap_state_s st_nxt;

  // follow pins during reset, freeze at release
  always_comb begin
    st_nxt = st_r;
    if (rst) begin
      st_nxt.lev = pins;
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  assign captured = st_r.lev;

endmodule : scs_por_capture

/* logic/scs_sysconfig_regs.sv */
// module: system configuration and status registers on an axi4-lite slave
//
// How it works
// RULE_01 - port 0 pins 23:0 captured at power-on reset into first capture register
// RULE_02 - all 32 port 1 pins captured at power-on reset into second register
// RULE_03 - both capture registers are read-only; writes never change them
// RULE_04 - two-bit reset level field picks one of four detector thresholds
// RULE_05 - interrupt level field bits 3:2 picks levels 1 to 3; 0 reserved
// RULE_06 - bit 4 lets a brown-out detection reset the chip; resets to 0
// RULE_07 - interrupt threshold crossing sends a brown-out request to interrupt controller
// RULE_08 - brown-out interrupt, and enabled reset, wake chip from all low-power modes
// RULE_09 - 26-bit calibration value, reset 0, drives the tick timer readback
// RULE_10 - eight-bit latency field sets minimum interrupt response, 0 to 255 cycles
// RULE_11 - interrupts always wait at least the programmed latency before service
// RULE_12 - latency field resets to 0x10
// RULE_13 - reserved bits read zero and ignore writes
`timescale 1ns/1ps
module scs_sysconfig_regs
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // register bus
  input  wire scs_axil_req_s           axil_req,
  output scs_axil_rsp_s                axil_rsp,
  // pins sampled at power-on
  input  wire logic [SCS_PORT0_W-1:0]  port0_pins,
  input  wire logic [SCS_PORT1_W-1:0]  port1_pins,
  // brown-out detector
  input  wire logic                    bod_irq_detect,
  input  wire logic                    bod_rst_detect,
  output logic      [1:0]              brownout_reset_level,
  output logic      [1:0]              brownout_irq_level,
  output logic                         brownout_reset_enable,
  // brown-out events
  output logic                         bod_irq_req,
  output logic                         bod_chip_reset,
  output logic                         bod_wake_req,
  // tick timer
  output logic      [SCS_CAL_W-1:0]    tick_timer_calibration_readback,
  // interrupt latency
  input  wire logic                    irq_pending,
  output logic                         irq_service,
  output logic      [SCS_LAT_W-1:0]    irq_latency
);

  typedef struct packed {
    logic                 aw_full;
    logic [31:0]          aw_addr;
    logic                 w_full;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    scs_bod_cfg_s         bod;
    logic [SCS_CAL_W-1:0] cal;
    logic [SCS_LAT_W-1:0] lat;
    logic                 bod_irq;
    logic                 bod_rst;
    logic                 wake;
  } scs_regs_s;

  scs_regs_s st_r;
  scs_regs_s st_nxt;

  logic [SCS_PORT0_W-1:0] port0_cap;
  logic [SCS_PORT1_W-1:0] port1_cap;

  // merge written bytes into an old word
  function automatic logic [31:0] scs_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : scs_merge

  // tell whether an address is one of ours
  function automatic logic scs_mapped(input logic [31:0] addr);
    return (addr == SCS_PORT0_CAP_ADDR) ||
           (addr == SCS_PORT1_CAP_ADDR) ||
           (addr == SCS_BOD_CTRL_ADDR)  ||
           (addr == SCS_TICK_CAL_ADDR)  ||
           (addr == SCS_IRQ_LAT_ADDR);
  endfunction : scs_mapped

  // configuration as a register word
  function automatic logic [31:0] scs_bod_word(input scs_bod_cfg_s cfg);
    logic [31:0] w;
    w = '0;
    w[SCS_BOD_RST_LSB +: SCS_BOD_LEV_W] = cfg.rst_lev;
    w[SCS_BOD_IRQ_LSB +: SCS_BOD_LEV_W] = cfg.irq_lev;
    w[SCS_BOD_RST_EN]                   = cfg.rst_en;
    return w;
  endfunction : scs_bod_word

  // port 0 capture
  scs_por_capture #(
    .WIDTH (SCS_PORT0_W)
  ) u_cap0 (
    .mclk     (mclk),
    .rst      (rst),
    .pins     (port0_pins),
    .captured (port0_cap)
  ); // see RULE_01

  // port 1 capture
  scs_por_capture #(
    .WIDTH (SCS_PORT1_W)
  ) u_cap1 (
    .mclk     (mclk),
    .rst      (rst),
    .pins     (port1_pins),
    .captured (port1_cap)
  ); // see RULE_02

  // minimum interrupt latency
  scs_irq_latency #(
    .LAT_W (SCS_LAT_W)
  ) u_lat (
    .mclk        (mclk),
    .rst         (rst),
    .latency     (st_r.lat),
    .irq_pending (irq_pending),
    .irq_service (irq_service)
  ); // see RULE_11

  // next state
  always_comb begin
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    aw_take = axil_req.awvalid && !st_r.aw_full && !st_r.bvalid;
    w_take  = axil_req.wvalid && !st_r.w_full && !st_r.bvalid;
    ar_take = axil_req.arvalid && !st_r.rvalid;
    wr_word = '0;
    rd_word = '0;
    st_nxt  = st_r;

    // write address channel
    if (aw_take) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_addr = axil_req.awaddr;
    end

    // write data channel
    if (w_take) begin
      st_nxt.w_full = 1'b1;
      st_nxt.w_data = axil_req.wdata;
      st_nxt.w_strb = axil_req.wstrb;
    end

    // write response retires
    if (st_r.bvalid && axil_req.bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // perform a write once both halves are held
    if (st_r.aw_full && st_r.w_full && !st_r.bvalid) begin
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = scs_mapped(st_r.aw_addr) ? SCS_RESP_OKAY : SCS_RESP_SLVERR;
      unique case (st_r.aw_addr)
        SCS_BOD_CTRL_ADDR: begin
          wr_word = scs_merge(scs_bod_word(st_r.bod), st_r.w_data, st_r.w_strb);
          st_nxt.bod.rst_lev = wr_word[SCS_BOD_RST_LSB +: SCS_BOD_LEV_W]; // see RULE_04
          st_nxt.bod.irq_lev = wr_word[SCS_BOD_IRQ_LSB +: SCS_BOD_LEV_W]; // see RULE_05
          st_nxt.bod.rst_en  = wr_word[SCS_BOD_RST_EN]; // see RULE_06
        end
        SCS_TICK_CAL_ADDR: begin
          wr_word = scs_merge({6'h00, st_r.cal}, st_r.w_data, st_r.w_strb);
          st_nxt.cal = wr_word[SCS_CAL_W-1:0]; // see RULE_09
        end
        SCS_IRQ_LAT_ADDR: begin
          wr_word = scs_merge({24'h00_0000, st_r.lat}, st_r.w_data, st_r.w_strb);
          st_nxt.lat = wr_word[SCS_LAT_W-1:0]; // see RULE_10
        end
        default: begin
          // capture registers and unmapped space keep their state
          wr_word = '0; // see RULE_03
        end
      endcase
    end

    // read response retires
    if (st_r.rvalid && axil_req.rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // read address channel
    if (ar_take) begin
      unique case (axil_req.araddr)
        SCS_PORT0_CAP_ADDR: rd_word = {8'h00, port0_cap}; // see RULE_13
        SCS_PORT1_CAP_ADDR: rd_word = port1_cap;
        SCS_BOD_CTRL_ADDR:  rd_word = scs_bod_word(st_r.bod); // see RULE_13
        SCS_TICK_CAL_ADDR:  rd_word = {6'h00, st_r.cal}; // see RULE_13
        SCS_IRQ_LAT_ADDR:   rd_word = {24'h00_0000, st_r.lat}; // see RULE_13
        default:            rd_word = '0;
      endcase
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_word;
      st_nxt.rresp  = scs_mapped(axil_req.araddr) ? SCS_RESP_OKAY : SCS_RESP_SLVERR;
    end

    // brown-out events
    st_nxt.bod_irq = bod_irq_detect; // see RULE_07
    st_nxt.bod_rst = bod_rst_detect && st_r.bod.rst_en; // see RULE_06
    st_nxt.wake    = bod_irq_detect || (bod_rst_detect && st_r.bod.rst_en); // see RULE_08

    // reset values
    if (rst) begin
      st_nxt.aw_full     = 1'b0;
      st_nxt.aw_addr     = '0;
      st_nxt.w_full      = 1'b0;
      st_nxt.w_data      = '0;
      st_nxt.w_strb      = '0;
      st_nxt.bvalid      = 1'b0;
      st_nxt.bresp       = SCS_RESP_OKAY;
      st_nxt.rvalid      = 1'b0;
      st_nxt.rdata       = '0;
      st_nxt.rresp       = SCS_RESP_OKAY;
      st_nxt.bod.rst_lev = SCS_BOD_RST_LEV_RST;
      st_nxt.bod.irq_lev = SCS_BOD_IRQ_LEV_RST;
      st_nxt.bod.rst_en  = SCS_BOD_RST_EN_RST; // see RULE_06
      st_nxt.cal         = SCS_CAL_RST; // see RULE_09
      st_nxt.lat         = SCS_LAT_RST; // see RULE_12
      st_nxt.bod_irq     = 1'b0;
      st_nxt.bod_rst     = 1'b0;
      st_nxt.wake        = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  // bus answers
  always_comb begin
    axil_rsp.awready = !st_r.aw_full && !st_r.bvalid;
    axil_rsp.wready  = !st_r.w_full && !st_r.bvalid;
    axil_rsp.bvalid  = st_r.bvalid;
    axil_rsp.bresp   = st_r.bresp;
    axil_rsp.arready = !st_r.rvalid;
    axil_rsp.rvalid  = st_r.rvalid;
    axil_rsp.rdata   = st_r.rdata;
    axil_rsp.rresp   = st_r.rresp;
  end

  // detector and event outputs
  assign brownout_reset_level            = st_r.bod.rst_lev; // see RULE_04
  assign brownout_irq_level              = st_r.bod.irq_lev; // see RULE_05
  assign brownout_reset_enable           = st_r.bod.rst_en;
  assign bod_irq_req                     = st_r.bod_irq; // see RULE_07
  assign bod_chip_reset                  = st_r.bod_rst; // see RULE_06
  assign bod_wake_req                    = st_r.wake; // see RULE_08
  assign tick_timer_calibration_readback = st_r.cal; // see RULE_09
  assign irq_latency                     = st_r.lat; // see RULE_10

endmodule : scs_sysconfig_regs

/* shared/scs_pkg.sv */
// package: register map, field layout, reset values and bus carriers
package scs_pkg;

  // bus widths
  localparam int unsigned SCS_ADDR_W = 32;
  localparam int unsigned SCS_DATA_W = 32;
  localparam int unsigned SCS_STRB_W = 4;

  // register byte addresses
  localparam logic [31:0] SCS_PORT0_CAP_ADDR = 32'h4004_8100;
  localparam logic [31:0] SCS_PORT1_CAP_ADDR = 32'h4004_8104;
  localparam logic [31:0] SCS_BOD_CTRL_ADDR  = 32'h4004_8150;
  localparam logic [31:0] SCS_TICK_CAL_ADDR  = 32'h4004_8154;
  localparam logic [31:0] SCS_IRQ_LAT_ADDR   = 32'h4004_8170;

  // field positions and widths
  localparam int unsigned SCS_PORT0_W      = 24;
  localparam int unsigned SCS_PORT1_W      = 32;
  localparam int unsigned SCS_BOD_RST_LSB  = 0;
  localparam int unsigned SCS_BOD_IRQ_LSB  = 2;
  localparam int unsigned SCS_BOD_LEV_W    = 2;
  localparam int unsigned SCS_BOD_RST_EN   = 4;
  localparam int unsigned SCS_CAL_W        = 26;
  localparam int unsigned SCS_LAT_W        = 8;

  // reset values
  localparam logic [1:0]  SCS_BOD_RST_LEV_RST = 2'h0;
  localparam logic [1:0]  SCS_BOD_IRQ_LEV_RST = 2'h0;
  localparam logic        SCS_BOD_RST_EN_RST  = 1'b0;
  localparam logic [25:0] SCS_CAL_RST         = 26'h000_0000;
  localparam logic [7:0]  SCS_LAT_RST         = 8'h10;

  // response codes
  localparam logic [1:0] SCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SCS_RESP_SLVERR = 2'h2;

  // axi4-lite master to slave
  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } scs_axil_req_s;

  // axi4-lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } scs_axil_rsp_s;

  // brown-out configuration
  typedef struct packed {
    logic       rst_en;
    logic [1:0] irq_lev;
    logic [1:0] rst_lev;
  } scs_bod_cfg_s;

endpackage : scs_pkg
